// ===== hdl/sacw_pkg.sv
// Purpose: shared constants for the sar converter control block
// Assumes: apb with 32-bit data, one register per aligned word
// Notes:   register indices times four give the byte address
package sacw_pkg;
    localparam int          APB_AW          = 12;
    // register indices
    localparam logic [7:0]  IDX_PAIR_CFG    = 8'hBA;
    localparam logic [7:0]  IDX_CONFIG      = 8'hBC;
    localparam logic [7:0]  IDX_RES_LOW     = 8'hBE;
    localparam logic [7:0]  IDX_RES_HIGH    = 8'hBF;
    localparam logic [7:0]  IDX_UP_LOW      = 8'hC4;
    localparam logic [7:0]  IDX_UP_HIGH     = 8'hC5;
    localparam logic [7:0]  IDX_LO_LOW      = 8'hC6;
    localparam logic [7:0]  IDX_LO_HIGH     = 8'hC7;
    localparam logic [7:0]  IDX_CONTROL     = 8'hE8;
    // reset values
    localparam logic [7:0]  RST_CONFIG      = 8'hF8;
    localparam logic [7:0]  RST_CONTROL     = 8'h00;
    localparam logic [7:0]  RST_RESULT      = 8'h00;
    localparam logic [7:0]  RST_UP          = 8'hFF;
    localparam logic [7:0]  RST_LO          = 8'h00;
    // config fields
    localparam int          CFG_DIV_LSB     = 3;
    localparam int          CFG_GAIN_LSB    = 0;
    // control fields
    localparam int          CTL_ENABLE      = 7;
    localparam int          CTL_TRACK       = 6;
    localparam int          CTL_DONE        = 5;
    localparam int          CTL_BUSY        = 4;
    localparam int          CTL_MODE_LSB    = 2;
    localparam int          CTL_WIN         = 1;
    localparam int          CTL_JUST        = 0;
    // start modes
    localparam logic [1:0]  MODE_SOFT       = 2'h0;
    localparam logic [1:0]  MODE_TMR3       = 2'h1;
    localparam logic [1:0]  MODE_EXT        = 2'h2;
    localparam logic [1:0]  MODE_TMR2       = 2'h3;
    // timing in sar clocks
    localparam logic [4:0]  TRACK_SAR_CLKS  = 5'h03;
    localparam logic [4:0]  CONV_SAR_CLKS   = 5'h10;
    typedef enum logic [1:0] {SACW_IDLE, SACW_TRACK, SACW_CONV} sacw_state_t;
endpackage

// ===== hdl/sacw_top.sv
// Purpose: control logic of a 10-bit sar converter with window detector
// Assumes: triggers and sar_code come from pclk logic; the pin is async
// Notes:   registers answer with no wait states
`timescale 1ns/1ps
// Summary of operation
// - nonzero divider: sar clock is system clock over two times divider plus two
// - divider zero: sar clock runs at full system clock
// - gain field maps 000..011 to 1,2,4,8; 10x to 16; 11x to 0.5
// - enable clear holds converter shut down; set accepts starts
// - track bit clear: track always except during conversion
// - done flag set when busy falls; only software clears it
// - busy reads 1 during a conversion, else 0
// - writing 1 to busy starts only in soft mode; 0 does nothing
// - start mode picks soft, timer 3, external rising edge, timer 2
// - track bit set, modes 00 01 11: track three sar clocks then convert
// - track bit set, mode 10: track while pin low, convert on rise
// - window flag set on a matching result, held until software clears
// - right justify: result in low ten bits, sign or zero above
// - left justify: eight msbs high, two lsbs top of low byte
// - code scales 2^10 single ended, 2^9 two's complement differential
// - each new result compared with upper and lower 16-bit limit words
// - window detector flags inside or outside depending on limit order
// - conversion lasts at least sixteen sar clocks until busy falls
// - differential results are two's complement, single ended unsigned
module sacw_top
    import sacw_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [APB_AW-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               timer3_overflow,
    input  wire logic               timer2_overflow,
    input  wire logic               external_convert_start,
    input  wire logic               channel_is_diff,
    input  wire logic [9:0]         sar_code,
    output logic                    converter_powered,
    output logic                    track_active,
    output logic                    convert_active,
    output logic                    sar_clock_tick,
    output logic [5:0]              gain_times_two
);
    logic [7:0]  converter_config_reg;
    logic [7:0]  converter_control_reg;
    logic [7:0]  result_low_byte_reg;
    logic [7:0]  result_high_byte_reg;
    logic [7:0]  window_upper_limit_low_reg;
    logic [7:0]  window_upper_limit_high_reg;
    logic [7:0]  window_lower_limit_low_reg;
    logic [7:0]  window_lower_limit_high_reg;
    logic [3:0]  input_pair_config_reg;
    logic [31:0] prdata_reg;
    sacw_state_t state_reg;
    logic [5:0]  div_cnt_reg;
    logic [4:0]  sar_cnt_reg;
    logic        ext_meta_reg;
    logic        ext_sync_reg;
    logic        ext_prev_reg;
    logic [4:0]  sar_clock_divider;
    logic [2:0]  amplifier_gain_select;
    logic        converter_enable;
    logic        track_mode_select;
    logic        conversion_done_flag;
    logic        conversion_busy;
    logic [1:0]  start_mode_select;
    logic        window_match_flag;
    logic        justify_select;
    logic [5:0]  div_last;
    logic        ext_rise;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  reg_idx;
    logic        addr_hit;
    logic        ctl_wr;
    logic        soft_start;
    logic        trigger;
    logic        start_now;
    logic        conv_end;
    logic [15:0] result_word;
    logic [15:0] upper_word;
    logic [15:0] lower_word;
    logic        window_hit;

    // gain as a multiple of one half, so 0.5 stays an integer
    function automatic logic [5:0] gain_decode(input logic [2:0] g);
        case (g[2:1])
            2'h0:    gain_decode = g[0] ? 6'h04 : 6'h02;
            2'h1:    gain_decode = g[0] ? 6'h10 : 6'h08;
            2'h2:    gain_decode = 6'h20;
            default: gain_decode = 6'h01;
        endcase
    endfunction

    // signed view when differential, so one comparator serves both formats
    function automatic logic signed [16:0] as_num(input logic [15:0] w,
                                                  input logic        sgn);
        as_num = $signed({sgn & w[15], w});
    endfunction

    assign sar_clock_divider     = converter_config_reg[CFG_DIV_LSB +: 5];
    assign amplifier_gain_select = converter_config_reg[CFG_GAIN_LSB +: 3];
    assign converter_enable      = converter_control_reg[CTL_ENABLE];
    assign track_mode_select     = converter_control_reg[CTL_TRACK];
    assign conversion_done_flag  = converter_control_reg[CTL_DONE];
    assign start_mode_select     = converter_control_reg[CTL_MODE_LSB +: 2];
    assign window_match_flag     = converter_control_reg[CTL_WIN];
    assign justify_select        = converter_control_reg[CTL_JUST];
    assign conversion_busy       = (state_reg != SACW_IDLE);

    assign gain_times_two = gain_decode(amplifier_gain_select);

    // apb decode
    assign reg_idx  = paddr[9:2];
    assign wr_en    = psel & penable & pwrite;
    assign rd_en    = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    assign prdata   = prdata_reg;
    always_comb
    begin
        case (reg_idx)
            IDX_PAIR_CFG, IDX_CONFIG, IDX_RES_LOW, IDX_RES_HIGH,
            IDX_UP_LOW, IDX_UP_HIGH, IDX_LO_LOW, IDX_LO_HIGH,
            IDX_CONTROL: addr_hit = (paddr[APB_AW-1:10] == '0) & (paddr[1:0] == 2'h0);
            default:     addr_hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_hit;
    assign ctl_wr  = wr_en & addr_hit & pstrb[0] & (reg_idx == IDX_CONTROL);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else if (rd_en)
        begin
            case (reg_idx)
                IDX_PAIR_CFG: prdata_reg <= {28'h0, input_pair_config_reg};
                IDX_CONFIG:   prdata_reg <= {24'h0, converter_config_reg};
                IDX_RES_LOW:  prdata_reg <= {24'h0, result_low_byte_reg};
                IDX_RES_HIGH: prdata_reg <= {24'h0, result_high_byte_reg};
                IDX_UP_LOW:   prdata_reg <= {24'h0, window_upper_limit_low_reg};
                IDX_UP_HIGH:  prdata_reg <= {24'h0, window_upper_limit_high_reg};
                IDX_LO_LOW:   prdata_reg <= {24'h0, window_lower_limit_low_reg};
                IDX_LO_HIGH:  prdata_reg <= {24'h0, window_lower_limit_high_reg};
                IDX_CONTROL:  prdata_reg <= {24'h0, converter_control_reg[7:5],
                                            conversion_busy, converter_control_reg[3:0]};
                default:      prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // plain read/write registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            converter_config_reg        <= RST_CONFIG;
            window_upper_limit_low_reg  <= RST_UP;
            window_upper_limit_high_reg <= RST_UP;
            window_lower_limit_low_reg  <= RST_LO;
            window_lower_limit_high_reg <= RST_LO;
            input_pair_config_reg       <= 4'h0;
        end
        else if (wr_en && addr_hit && pstrb[0])
        begin
            case (reg_idx)
                IDX_CONFIG:   converter_config_reg        <= pwdata[7:0];
                IDX_UP_LOW:   window_upper_limit_low_reg  <= pwdata[7:0];
                IDX_UP_HIGH:  window_upper_limit_high_reg <= pwdata[7:0];
                IDX_LO_LOW:   window_lower_limit_low_reg  <= pwdata[7:0];
                IDX_LO_HIGH:  window_lower_limit_high_reg <= pwdata[7:0];
                IDX_PAIR_CFG: input_pair_config_reg       <= pwdata[3:0];
                default:      ;
            endcase
        end
    end

    // the pin is asynchronous; the first stage is never looked at
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end
        else
        begin
            ext_meta_reg <= external_convert_start;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end
    assign ext_rise = ext_sync_reg & ~ext_prev_reg;

    // sar clock divider, restarted at each start so periods are whole
    // last count is period minus one, so divider 31 (period 64) still fits six bits
    assign div_last = (sar_clock_divider == 5'h00) ? 6'h00
                    : {sar_clock_divider, 1'b0} + 6'h01;
    // at or beyond the last count, so a smaller divider written mid-count ticks at once
    assign sar_clock_tick = converter_enable & (div_cnt_reg >= div_last);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt_reg <= 6'h00;
        else if (!converter_enable || start_now || sar_clock_tick)
            div_cnt_reg <= 6'h00;
        else
            div_cnt_reg <= div_cnt_reg + 6'h01;
    end

    // trigger selection
    assign soft_start = ctl_wr & pwdata[CTL_BUSY] & (start_mode_select == MODE_SOFT);
    always_comb
    begin
        case (start_mode_select)
            MODE_SOFT: trigger = soft_start;
            MODE_TMR3: trigger = timer3_overflow;
            MODE_EXT:  trigger = ext_rise;
            MODE_TMR2: trigger = timer2_overflow;
            default:   trigger = 1'b0;
        endcase
    end
    // busy or disabled converters drop triggers
    assign start_now = trigger & converter_enable & (state_reg == SACW_IDLE);
    assign conv_end  = (state_reg == SACW_CONV) & sar_clock_tick
                     & (sar_cnt_reg == CONV_SAR_CLKS - 5'h01);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg   <= SACW_IDLE;
            sar_cnt_reg <= 5'h00;
        end
        else if (!converter_enable)
        begin
            state_reg   <= SACW_IDLE;
            sar_cnt_reg <= 5'h00;
        end
        else
        begin
            case (state_reg)
                SACW_IDLE:
                begin
                    sar_cnt_reg <= 5'h00;
                    if (start_now)
                        state_reg <= (track_mode_select && start_mode_select != MODE_EXT)
                                   ? SACW_TRACK : SACW_CONV;
                end
                SACW_TRACK:
                begin
                    if (sar_clock_tick && sar_cnt_reg == TRACK_SAR_CLKS - 5'h01)
                    begin
                        state_reg   <= SACW_CONV;
                        sar_cnt_reg <= 5'h00;
                    end
                    else if (sar_clock_tick)
                        sar_cnt_reg <= sar_cnt_reg + 5'h01;
                end
                SACW_CONV:
                begin
                    if (conv_end)
                    begin
                        state_reg   <= SACW_IDLE;
                        sar_cnt_reg <= 5'h00;
                    end
                    else if (sar_clock_tick)
                        sar_cnt_reg <= sar_cnt_reg + 5'h01;
                end
                default:
                begin
                    state_reg   <= SACW_IDLE;
                    sar_cnt_reg <= 5'h00;
                end
            endcase
        end
    end

    // analog side controls
    assign converter_powered = converter_enable;
    // the state leaves conv one cycle after enable clears; the output drops at once
    assign convert_active    = (state_reg == SACW_CONV) & converter_enable;
    always_comb
    begin
        if (!converter_enable)
            track_active = 1'b0;
        else if (!track_mode_select)
            track_active = (state_reg != SACW_CONV);
        else if (start_mode_select == MODE_EXT)
            track_active = (state_reg == SACW_IDLE) & ~ext_sync_reg;
        else
            track_active = (state_reg == SACW_TRACK);
    end

    // result formatting; sar_code is two's complement on a differential pair
    always_comb
    begin
        if (justify_select)
            result_word = {sar_code, 6'h00};
        else
            result_word = {{6{channel_is_diff & sar_code[9]}}, sar_code};
    end
    assign upper_word = {window_upper_limit_high_reg, window_upper_limit_low_reg};
    assign lower_word = {window_lower_limit_high_reg, window_lower_limit_low_reg};
    always_comb
    begin
        if (as_num(lower_word, channel_is_diff) > as_num(upper_word, channel_is_diff))
            window_hit = (as_num(result_word, channel_is_diff) >
                          as_num(upper_word, channel_is_diff)) &&
                         (as_num(result_word, channel_is_diff) <
                          as_num(lower_word, channel_is_diff));
        else
            window_hit = (as_num(result_word, channel_is_diff) >
                          as_num(upper_word, channel_is_diff)) ||
                         (as_num(result_word, channel_is_diff) <
                          as_num(lower_word, channel_is_diff));
    end

    // result bytes load as busy falls; software writes are taken otherwise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_low_byte_reg  <= RST_RESULT;
            result_high_byte_reg <= RST_RESULT;
        end
        else if (conv_end)
        begin
            result_low_byte_reg  <= result_word[7:0];
            result_high_byte_reg <= result_word[15:8];
        end
        else if (wr_en && addr_hit && pstrb[0] && reg_idx == IDX_RES_LOW)
            result_low_byte_reg  <= pwdata[7:0];
        else if (wr_en && addr_hit && pstrb[0] && reg_idx == IDX_RES_HIGH)
            result_high_byte_reg <= pwdata[7:0];
    end

    // control register; hardware sets win over a clearing write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            converter_control_reg <= RST_CONTROL;
        else
        begin
            if (ctl_wr)
            begin
                converter_control_reg[7:6] <= pwdata[7:6];
                converter_control_reg[3:2] <= pwdata[3:2];
                converter_control_reg[0]   <= pwdata[0];
            end
            converter_control_reg[CTL_BUSY] <= 1'b0;
            if (conv_end)
                converter_control_reg[CTL_DONE] <= 1'b1;
            else if (ctl_wr)
                converter_control_reg[CTL_DONE] <= pwdata[CTL_DONE];
            if (conv_end && window_hit)
                converter_control_reg[CTL_WIN] <= 1'b1;
            else if (ctl_wr)
                converter_control_reg[CTL_WIN] <= pwdata[CTL_WIN];
        end
    end

    // checks
    logic [9:0] conv_cyc_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            conv_cyc_reg <= 10'h000;
        else if (state_reg != SACW_CONV)
            conv_cyc_reg <= 10'h000;
        else if (conv_cyc_reg != 10'h3FF)
            conv_cyc_reg <= conv_cyc_reg + 10'h001;
    end

    a_div_full_rate: assert property (@(posedge pclk) disable iff (!presetn)
        (converter_enable && sar_clock_divider == 5'h00) |-> sar_clock_tick)
        else $error("divider zero did not run at full rate");
    a_div_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        (sar_clock_tick && sar_clock_divider == 5'h01 && !start_now)
        ##1 (sar_clock_divider == 5'h01 && !start_now && converter_enable)[*4]
        |-> sar_clock_tick)
        else $error("sar clock period wrong for divider one");
    a_busy_sets_done: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(conversion_busy) && converter_enable) |-> conversion_done_flag)
        else $error("busy fell without done flag");
    a_done_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (conversion_done_flag && !ctl_wr) |=> conversion_done_flag)
        else $error("done flag cleared by hardware");
    a_soft_start: assert property (@(posedge pclk) disable iff (!presetn)
        (soft_start && converter_enable && !conversion_busy) |=> conversion_busy)
        else $error("soft start ignored");
    a_disabled_off: assert property (@(posedge pclk) disable iff (!presetn)
        !converter_enable |-> (!track_active && !convert_active))
        else $error("disabled converter active");
    a_track_three: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SACW_CONV && $past(state_reg) == SACW_TRACK)
        |-> $past(sar_cnt_reg) == 5'h02)
        else $error("track phase not three sar clocks");
    a_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
        conv_end |-> conv_cyc_reg >= 10'h00F)
        else $error("conversion too short");
    a_left_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_end && justify_select) |=> result_low_byte_reg[5:0] == 6'h00)
        else $error("left justified low bits not zero");
    a_right_unsigned: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_end && !justify_select && !channel_is_diff)
        |=> result_high_byte_reg[7:2] == 6'h00)
        else $error("single ended high bits not zero");
    a_window_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_end && window_hit) |=> window_match_flag)
        else $error("window match not flagged");
    a_busy_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == SACW_CONV && !conv_end && converter_enable)
        |=> state_reg == SACW_CONV)
        else $error("conversion restarted or aborted");

    c_soft_conv: cover property (@(posedge pclk) disable iff (!presetn)
        soft_start ##[1:600] conv_end);
    c_ext_conv: cover property (@(posedge pclk) disable iff (!presetn)
        (start_mode_select == MODE_EXT && start_now) ##[1:600] conv_end);
    c_window: cover property (@(posedge pclk) disable iff (!presetn)
        conv_end && window_hit);
    c_track_mode: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == SACW_TRACK ##[1:300] state_reg == SACW_CONV);
endmodule

// ===== bench/sacw_tb.sv
// Purpose: self-checking bench for the sar converter control block
// Assumes: master waits on pready; small dividers keep the run short
// Notes:   expected bytes and flags come from an integer model in the bench
`timescale 1ns/1ps
module tb import sacw_pkg::*; ;
    logic        pclk, presetn, psel, penable, pwrite, t3_ov, t2_ov, ext_pin, is_diff;
    logic        pready, pslverr, serr, conv_on, pwr, trk, tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [9:0]  code;
    logic [5:0]  gain2;
    logic [5:0]  gtab [8] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h20, 6'h01, 6'h01};
    int          errors, n_checks, cyc, conv_cnt, tk_cnt, trk_cnt;

    sacw_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer3_overflow(t3_ov),
        .timer2_overflow(t2_ov), .external_convert_start(ext_pin),
        .channel_is_diff(is_diff), .sar_code(code), .converter_powered(pwr),
        .track_active(trk), .convert_active(conv_on), .sar_clock_tick(tick),
        .gain_times_two(gain2));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // a hang must still reach the closing report
    always @(posedge pclk)
    begin
        cyc++;
        if (conv_on === 1'b1)
            conv_cnt++;
        if (conv_on === 1'b1 && tick === 1'b1)
            tk_cnt++;
        if (trk === 1'b1)
            trk_cnt++;
        if (cyc == 50000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request stands until pready is seen high at a rising edge; data taken there
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd   = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [15:0] fmt(input logic [9:0] c, input logic d, input logic lj);
        return lj ? {c, 6'h00} : (d ? {{6{c[9]}}, c} : {6'h00, c});
    endfunction

    function automatic logic hit(input logic [15:0] r, up, lo, input logic d);
        int ri, ui, li;
        ri = d ? int'($signed(r)) : int'(r);
        ui = d ? int'($signed(up)) : int'(up);
        li = d ? int'($signed(lo)) : int'(lo);
        return (li > ui) ? (ui < ri && ri < li) : (ri > ui || ri < li);
    endfunction

    task automatic cnv(input logic [1:0] m, input logic tm, lj, d, input logic [4:0] dv,
                       input logic [15:0] up, lo);
        logic [15:0] r;
        int          p;
        p = (dv == 0) ? 1 : 2 * (dv + 1);
        apb(1'b1, IDX_CONFIG, {dv, 3'h0});
        apb(1'b1, IDX_UP_HIGH, up[15:8]);
        apb(1'b1, IDX_UP_LOW, up[7:0]);
        apb(1'b1, IDX_LO_HIGH, lo[15:8]);
        apb(1'b1, IDX_LO_LOW, lo[7:0]);
        code     <= 10'($urandom);
        is_diff  <= d;
        conv_cnt = 0;
        tk_cnt   = 0;
        // enable and mode first: a start is judged on the mode already held
        apb(1'b1, IDX_CONTROL, {1'b1, tm, 2'b00, m, 1'b0, lj});
        @(negedge pclk);
        chk(pwr, 1'b1);
        chk(trk, !tm || m == MODE_EXT);
        trk_cnt = 0;
        apb(1'b1, IDX_CONTROL, {1'b1, tm, 2'b01, m, 1'b0, lj});
        if (m != MODE_SOFT)
        begin
            apb(1'b0, IDX_CONTROL, 8'h00);
            chk(rd[4], 1'b0);
            t3_ov   <= (m == MODE_TMR3);
            t2_ov   <= (m == MODE_TMR2);
            ext_pin <= (m == MODE_EXT);
            @(posedge pclk);
            t3_ov <= 1'b0;
            t2_ov <= 1'b0;
        end
        for (int i = 0; i < 200 && conv_on !== 1'b1; i++)
            @(negedge pclk);
        rd = 32'h10;
        for (int i = 0; i < 300 && rd[4] !== 1'b0; i++)
            apb(1'b0, IDX_CONTROL, 8'h00);
        ext_pin <= 1'b0;
        chk(conv_cnt, 16 * p);
        chk(tk_cnt, 16);
        if (tm && m != MODE_EXT)
            chk(trk_cnt, 3 * p);
        r = fmt(code, d, lj);
        apb(1'b0, IDX_RES_HIGH, 8'h00);
        chk(rd, r[15:8]);
        apb(1'b0, IDX_RES_LOW, 8'h00);
        chk(rd, r[7:0]);
        apb(1'b0, IDX_CONTROL, 8'h00);
        chk(rd, {1'b1, tm, 2'b10, m, hit(r, up, lo, d), lj});
        apb(1'b1, IDX_CONTROL, 8'h80);
        apb(1'b0, IDX_CONTROL, 8'h00);
        chk(rd, 8'h80);
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, t3_ov, t2_ov, ext_pin, is_diff} = '0;
        paddr  = '0;
        pwdata = '0;
        pstrb  = 4'hF;
        code   = '0;
        void'($urandom(32'h70BA));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDX_CONFIG, 8'h00);
        chk(rd, RST_CONFIG);
        apb(1'b0, IDX_UP_LOW, 8'h00);
        chk(rd, RST_UP);
        apb(1'b0, IDX_CONTROL, 8'h00);
        chk(rd, RST_CONTROL);
        apb(1'b0, 8'h01, 8'h00);
        chk({rd[30:0], serr}, 32'h1);
        for (int g = 0; g < 8; g++)
        begin
            apb(1'b1, IDX_CONFIG, 8'(g));
            @(negedge pclk);
            chk(gain2, gtab[g]);
        end
        cnv(MODE_SOFT, 1'b0, 1'b0, 1'b0, 5'd0, 16'h0100, 16'h0080);
        cnv(MODE_TMR3, 1'b0, 1'b1, 1'b0, 5'd1, 16'h4000, 16'hC000);
        cnv(MODE_EXT, 1'b1, 1'b0, 1'b1, 5'd0, 16'hFFF0, 16'h0010);
        cnv(MODE_TMR2, 1'b1, 1'b1, 1'b1, 5'd2, 16'h0000, 16'h0000);
        cnv(MODE_SOFT, 1'b1, 1'b0, 1'b1, 5'd0, 16'h0100, 16'hFF00);
        for (int i = 0; i < 4; i++)
            cnv(MODE_SOFT, 1'b0, i[0], i[1], 5'd0, 16'($urandom), 16'($urandom));
        tally_and_finish();
    end
endmodule
